// File: sgp_pkg.sv
package sgp_pkg;

    // widths
    localparam int unsigned PORT_W = 6;
    localparam int unsigned IRQ_W  = 4;
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_PORT_PIN_DATA      = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_PORT_PIN_DIRECTION = 2'h1;
    localparam logic [ADDR_W-1:0] OFS_PULLDOWN_INHIBIT   = 2'h2;
    localparam logic [ADDR_W-1:0] OFS_OPTION_REGISTER    = 2'h3;

    // pulldown inhibit control field positions
    localparam int unsigned PD_THIRD_LOWER_BIT = 6;
    localparam int unsigned PD_THIRD_UPPER_BIT = 7;

    // option register field positions
    localparam int unsigned OPT_GLOBAL_PD_DISABLE_BIT = 0;
    localparam int unsigned OPT_PORT_IRQ_BIT          = 1;
    localparam int unsigned OPT_LEVEL_SENSE_BIT       = 2;
    localparam int unsigned OPT_W                     = 3;

    // pins that the comparators may drive
    localparam int unsigned CMP_PIN_LO = 4;
    localparam int unsigned CMP_W      = 2;

    // reset values, and the filler read from the write-only register
    localparam logic [PORT_W-1:0] DIR_RST     = 6'h00;
    localparam logic [PORT_W-1:0] PD_INH_RST  = 6'h00;
    localparam logic [OPT_W-1:0]  OPT_RST     = 3'h0;
    localparam logic [DATA_W-1:0] RDATA_RST   = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_UNDEF = 8'h00;

    // bus request from the processor side
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } sgp_bus_req_s;

    // pad controls for the six pins
    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
        logic [PORT_W-1:0] pd_en;
    } sgp_pad_s;

    // all controlled state of the port except the data latch
    typedef struct packed {
        logic [PORT_W-1:0] dir;
        logic [PORT_W-1:0] pd_inh;
        logic              third_upper_inh;
        logic              third_lower_inh;
        logic [OPT_W-1:0]  opt;
        logic [IRQ_W-1:0]  pins_prev;
        logic              edge_pend;
        logic              irq;
        logic              third_upper_pd;
        logic              third_lower_pd;
        logic              int_pin_level;
        sgp_pad_s          pad;
        logic [DATA_W-1:0] rdata;
    } sgp_state_s;

endpackage : sgp_pkg

// File: sgp_port.sv
`timescale 1ns/100ps

module sgp_port (
    // clock and reset
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_n_i,
    // register port
    input  wire sgp_pkg::sgp_bus_req_s         bus_req_i,
    output logic [sgp_pkg::DATA_W-1:0]         rdata_o,
    // pins
    input  wire logic [sgp_pkg::PORT_W-1:0]    port_pins_i,
    output sgp_pkg::sgp_pad_s                  pad_o,
    // comparator drive onto the top two pins
    input  wire logic [sgp_pkg::CMP_W-1:0]     cmp_drive_i,
    // dedicated interrupt pin and branch test level
    input  wire logic                          int_pin_i,
    output logic                               int_pin_level_o,
    // port interrupt request and acknowledge
    input  wire logic                          irq_ack_i,
    output logic                               irq_o,
    // third port pulldown permits, gated by its own direction outside
    output logic                               third_upper_pd_o,
    output logic                               third_lower_pd_o
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers

    logic [1:0]                      rst_sync;
    logic                            rst_n;
    logic [sgp_pkg::PORT_W-1:0]      pins_meta;
    logic [sgp_pkg::PORT_W-1:0]      pins_sync;
    logic                            int_meta;
    logic                            int_sync;

    // release is synchronised so every flop reset by rst_n leaves reset on the same edge
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // pins are asynchronous; first stage feeds only the second
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pins_meta <= 6'h00;
            pins_sync <= 6'h00;
            int_meta  <= 1'b1;
            int_sync  <= 1'b1;
        end else begin
            pins_meta <= port_pins_i;
            pins_sync <= pins_meta;
            int_meta  <= int_pin_i;
            int_sync  <= int_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data latch, deliberately outside reset

    logic [sgp_pkg::PORT_W-1:0]      data_latch;
    logic [sgp_pkg::PORT_W-1:0]      next_data_latch;
    logic                            wr_data;

    assign wr_data = bus_req_i.wr && (bus_req_i.addr == sgp_pkg::OFS_PORT_PIN_DATA);

    // any write lands, input or output; unused upper bits dropped
    always_comb begin
        next_data_latch = data_latch;
        if (wr_data) begin
            next_data_latch = bus_req_i.wdata[sgp_pkg::PORT_W-1:0];
        end
    end

    // no reset term: latch contents survive a reset
    always_ff @(posedge ref_clk_i) begin
        data_latch <= next_data_latch;
    end

    ////////////////////////////////////////////////////////////////////////////
    // control state

    sgp_pkg::sgp_state_s             st;
    sgp_pkg::sgp_state_s             next_st;
    logic                            pd_global_off;
    logic [sgp_pkg::IRQ_W-1:0]       irq_pins;
    logic                            irq_en;
    logic                            edge_seen;

    assign pd_global_off = st.opt[sgp_pkg::OPT_GLOBAL_PD_DISABLE_BIT];
    assign irq_en        = st.opt[sgp_pkg::OPT_PORT_IRQ_BIT];
    assign irq_pins      = pins_sync[sgp_pkg::IRQ_W-1:0];
    assign edge_seen     = |(irq_pins & ~st.pins_prev);

    // register writes, reads, interrupt sensing and pad drive
    always_comb begin
        next_st = st;
        next_st.pins_prev = irq_pins;

        // register writes
        if (bus_req_i.wr) begin
            case (bus_req_i.addr)
                sgp_pkg::OFS_PORT_PIN_DIRECTION: begin
                    next_st.dir = bus_req_i.wdata[sgp_pkg::PORT_W-1:0];
                end
                sgp_pkg::OFS_PULLDOWN_INHIBIT: begin
                    next_st.pd_inh = bus_req_i.wdata[sgp_pkg::PORT_W-1:0];
                    next_st.third_upper_inh =
                        bus_req_i.wdata[sgp_pkg::PD_THIRD_UPPER_BIT];
                    next_st.third_lower_inh =
                        bus_req_i.wdata[sgp_pkg::PD_THIRD_LOWER_BIT];
                end
                sgp_pkg::OFS_OPTION_REGISTER: begin
                    next_st.opt = bus_req_i.wdata[sgp_pkg::OPT_W-1:0];
                end
                default: begin
                    next_st.opt = st.opt;
                end
            endcase
        end

        // read data, valid the cycle after the strobe only
        next_st.rdata = sgp_pkg::RDATA_RST;
        if (bus_req_i.rd) begin
            case (bus_req_i.addr)
                sgp_pkg::OFS_PORT_PIN_DATA: begin
                    // outputs read the latch, inputs read the pin
                    next_st.rdata = {2'h0, (st.dir & data_latch)
                                          | (~st.dir & pins_sync)};
                end
                sgp_pkg::OFS_PORT_PIN_DIRECTION: begin
                    next_st.rdata = {2'h0, st.dir};
                end
                sgp_pkg::OFS_PULLDOWN_INHIBIT: begin
                    next_st.rdata = sgp_pkg::RDATA_UNDEF;
                end
                default: begin
                    next_st.rdata = {5'h00, st.opt};
                end
            endcase
        end

        // edge latch; a new edge beats a same-cycle acknowledge
        if (irq_ack_i) begin
            next_st.edge_pend = 1'b0;
        end
        if (irq_en && edge_seen) begin
            next_st.edge_pend = 1'b1;
        end
        if (!irq_en) begin
            next_st.edge_pend = 1'b0;
        end
        next_st.irq = irq_en && (next_st.edge_pend
                      || (st.opt[sgp_pkg::OPT_LEVEL_SENSE_BIT] && |irq_pins));

        // branch test follows the dedicated pin alone
        next_st.int_pin_level = int_sync;

        // pad drive, from the state being loaded this edge
        next_st.pad.oe  = next_st.dir;
        next_st.pad.out = next_data_latch;
        // comparators only reach a pin that software made an output
        next_st.pad.out[sgp_pkg::CMP_PIN_LO +: sgp_pkg::CMP_W] =
            next_data_latch[sgp_pkg::CMP_PIN_LO +: sgp_pkg::CMP_W]
            | (cmp_drive_i & next_st.dir[sgp_pkg::CMP_PIN_LO +: sgp_pkg::CMP_W]);
        next_st.pad.pd_en = next_st.opt[sgp_pkg::OPT_GLOBAL_PD_DISABLE_BIT]
                            ? 6'h00
                            : (~next_st.pd_inh & ~next_st.dir);
        next_st.third_upper_pd = !next_st.opt[sgp_pkg::OPT_GLOBAL_PD_DISABLE_BIT]
                                 && !next_st.third_upper_inh;
        next_st.third_lower_pd = !next_st.opt[sgp_pkg::OPT_GLOBAL_PD_DISABLE_BIT]
                                 && !next_st.third_lower_inh;
    end

    // reset brings inputs everywhere, pulldowns all on
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st                 <= '0;
            st.dir             <= sgp_pkg::DIR_RST;
            st.pd_inh          <= sgp_pkg::PD_INH_RST;
            st.third_upper_inh <= 1'b0;
            st.third_lower_inh <= 1'b0;
            st.opt             <= sgp_pkg::OPT_RST;
            st.int_pin_level   <= 1'b1;
            st.third_upper_pd  <= 1'b1;
            st.third_lower_pd  <= 1'b1;
            st.pad.pd_en       <= 6'h3f;
            st.rdata           <= sgp_pkg::RDATA_RST;
        end else begin
            st <= next_st;
        end
    end

    // every output straight from a flop
    assign rdata_o          = st.rdata;
    assign pad_o            = st.pad;
    assign int_pin_level_o  = st.int_pin_level;
    assign irq_o            = st.irq;
    assign third_upper_pd_o = st.third_upper_pd;
    assign third_lower_pd_o = st.third_lower_pd;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking chk_cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n);

    sequence dir_write_s;
        bus_req_i.wr && bus_req_i.addr == sgp_pkg::OFS_PORT_PIN_DIRECTION;
    endsequence

    sequence data_read_s;
        bus_req_i.rd && bus_req_i.addr == sgp_pkg::OFS_PORT_PIN_DATA;
    endsequence

    chk_output_drive: assert property (
        pad_o.oe[0] && !cmp_drive_i[0] |-> pad_o.out[0] == data_latch[0])
        else $error("output pin not driving its latch bit");

    chk_data_upper_zero: assert property (
        data_read_s |=> rdata_o[7:6] == 2'h0)
        else $error("data upper bits not zero");

    chk_dir_readback: assert property (
        dir_write_s ##1 (bus_req_i.rd && bus_req_i.addr == sgp_pkg::OFS_PORT_PIN_DIRECTION)
        |=> rdata_o == {2'h0, $past(bus_req_i.wdata[5:0], 2)})
        else $error("direction readback mismatch");

    chk_dir_enables: assert property (
        dir_write_s |=> pad_o.oe == $past(bus_req_i.wdata[5:0]))
        else $error("driver enable does not follow direction write");

    chk_pulldown_rule: assert property (
        pad_o.pd_en == (pd_global_off ? 6'h00 : (~st.pd_inh & ~st.dir)))
        else $error("pulldown enable wrong");

    chk_read_mix: assert property (
        data_read_s |=> rdata_o[5:0] == (($past(st.dir) & $past(data_latch))
                        | (~$past(st.dir) & $past(pins_sync))))
        else $error("data read mixes latch and pin wrongly");

    chk_latch_write: assert property (
        bus_req_i.wr && bus_req_i.addr == sgp_pkg::OFS_PORT_PIN_DATA
        |=> data_latch == $past(bus_req_i.wdata[5:0]))
        else $error("data latch write lost");

    chk_edge_wake: assert property (
        irq_en && !$past(irq_ack_i) && $rose(irq_pins[0]) |=> irq_o)
        else $error("rising edge did not raise request");

    chk_irq_off: assert property (
        !irq_en |=> !irq_o)
        else $error("request while port interrupts disabled");

    chk_branch_level: assert property (
        int_pin_level_o == $past(int_sync))
        else $error("branch level not from dedicated pin");

    // read strobes of the other two registers
    sequence dir_read_s;
        bus_req_i.rd && bus_req_i.addr == sgp_pkg::OFS_PORT_PIN_DIRECTION;
    endsequence

    sequence pd_read_s;
        bus_req_i.rd && bus_req_i.addr == sgp_pkg::OFS_PULLDOWN_INHIBIT;
    endsequence

    // interrupt sensing modes, as loaded in the option bits
    sequence edge_mode_s;
        irq_en && !st.opt[sgp_pkg::OPT_LEVEL_SENSE_BIT];
    endsequence

    sequence level_high_s;
        irq_en && st.opt[sgp_pkg::OPT_LEVEL_SENSE_BIT] && |irq_pins;
    endsequence

    // no strobe, so the read port must rest at zero
    chk_rdata_rest: assert property (
        !bus_req_i.rd |=> rdata_o == sgp_pkg::RDATA_RST)
        else $error("read port not at rest");

    // write-only register gives the fixed filler value
    chk_pd_read_undef: assert property (
        pd_read_s |=> rdata_o == sgp_pkg::RDATA_UNDEF)
        else $error("pulldown register read not filler");

    // direction upper bits never read back
    chk_dir_upper_zero: assert property (
        dir_read_s |=> rdata_o[7:6] == 2'h0)
        else $error("direction upper bits not zero");

    // a driven pin must never also be pulled down
    chk_driver_no_pd: assert property (
        (pad_o.oe & pad_o.pd_en) == '0)
        else $error("pulldown on a driven pin");

    // driver enables are the direction bits, pin by pin
    chk_oe_is_dir: assert property (
        pad_o.oe == st.dir)
        else $error("driver enable differs from direction");

    // global disable beats every inhibit bit
    chk_global_pd_off: assert property (
        pd_global_off |-> pad_o.pd_en == '0 && !third_upper_pd_o && !third_lower_pd_o)
        else $error("pulldown on under global disable");

    // third port upper group follows its own inhibit bit
    chk_third_upper_pd: assert property (
        third_upper_pd_o == (!pd_global_off && !st.third_upper_inh))
        else $error("third port upper pulldown wrong");

    // third port lower group follows its own inhibit bit
    chk_third_lower_pd: assert property (
        third_lower_pd_o == (!pd_global_off && !st.third_lower_inh))
        else $error("third port lower pulldown wrong");

    // comparators cannot raise a pin that is not an output
    chk_cmp_gated: assert property (
        (pad_o.oe[sgp_pkg::CMP_PIN_LO +: sgp_pkg::CMP_W]
         | data_latch[sgp_pkg::CMP_PIN_LO +: sgp_pkg::CMP_W]) == '0
        |-> pad_o.out[sgp_pkg::CMP_PIN_LO +: sgp_pkg::CMP_W] == '0)
        else $error("comparator reached an input pin");

    // edge mode holds the request until acknowledged
    chk_edge_held: assert property (
        edge_mode_s ##0 (irq_o && !irq_ack_i) |=> irq_o)
        else $error("edge request dropped without acknowledge");

    // acknowledge with no fresh edge clears an edge request
    chk_ack_clears: assert property (
        edge_mode_s ##0 (irq_ack_i && !edge_seen) |=> !irq_o)
        else $error("acknowledge did not clear request");

    // a high level requests in level mode
    chk_level_request: assert property (
        level_high_s |=> irq_o)
        else $error("high level did not request");

    // first cycle out of reset: inputs only, pulldowns on, no request
    chk_reset_state: assert property (
        $rose(rst_n) |-> pad_o.oe == '0 && pad_o.pd_en == '1 && !irq_o)
        else $error("state after reset wrong");

    // port pin activity never moves the branch level
    chk_branch_isolated: assert property (
        $changed(irq_pins) && $stable(int_sync) |=> $stable(int_pin_level_o))
        else $error("branch level moved with port pins");

endmodule : sgp_port

// File: sgp_pin_model.sv
`timescale 1ns/100ps

// outside circuits on the six pins: a driver, the pulldowns, or nothing
module sgp_pin_model (
    // clock
    input  wire logic                       ref_clk_i,
    // pad controls from the port
    input  wire sgp_pkg::sgp_pad_s          pad_i,
    // outside driver, set by the bench
    input  wire logic [sgp_pkg::PORT_W-1:0] ext_en_i,
    input  wire logic [sgp_pkg::PORT_W-1:0] ext_val_i,
    // resolved pin levels
    output logic [sgp_pkg::PORT_W-1:0]      pins_o
);
    logic [sgp_pkg::PORT_W-1:0] flt;

    ////////////////////////////////////////////////////////////////////////////////
    // a floating pin wanders every cycle so a stale level never passes for data
    initial flt = 6'h15;
    always @(posedge ref_clk_i) begin
        flt <= ~flt;
    end

    // port driver first, then outside driver; an enabled pulldown pulls to 0
    assign pins_o = (pad_i.oe & pad_i.out) | (~pad_i.oe & ext_en_i & ext_val_i)
                  | (~pad_i.oe & ~ext_en_i & ~pad_i.pd_en & flt);
endmodule : sgp_pin_model

// File: tb_top.sv
`timescale 1ns/100ps

module tb_top;
    logic                  ref_clk_i, rst_n_i, int_pin_i, irq_ack_i;
    logic                  int_pin_level_o, irq_o, upper_pd, lower_pd;
    sgp_pkg::sgp_bus_req_s bus;
    sgp_pkg::sgp_pad_s     pad;
    logic [7:0]            rdata_o, rv;
    logic [5:0]            pins, ext_en, ext_val;
    logic [1:0]            cmp_drive;
    int                    miscompares, tests_run;

    ////////////////////////////////////////////////////////////////////////////////
    // design and the circuits on its pins
    sgp_port i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_req_i(bus),
        .rdata_o(rdata_o), .port_pins_i(pins), .pad_o(pad), .cmp_drive_i(cmp_drive),
        .int_pin_i(int_pin_i), .int_pin_level_o(int_pin_level_o), .irq_ack_i(irq_ack_i),
        .irq_o(irq_o), .third_upper_pd_o(upper_pd), .third_lower_pd_o(lower_pd));
    sgp_pin_model i_pins (.ref_clk_i(ref_clk_i), .pad_i(pad), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pins_o(pins));

    // 100 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // one-cycle write strobe; the next call waits for a fresh edge
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_i);
        bus.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_i);
        bus.rd <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : cyc

    task automatic do_reset();
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        cyc(3);
    endtask : do_reset

    // bounded wait for the port request to rise
    task automatic wait_irq();
        repeat (8) if (irq_o !== 1'b1) @(posedge ref_clk_i);
        #1 chk("irq", {7'h0, irq_o}, 8'h01);
    endtask : wait_irq

    task automatic ack();
        @(posedge ref_clk_i);
        irq_ack_i <= 1'b1;
        @(posedge ref_clk_i);
        irq_ack_i <= 1'b0;
        cyc(2);
    endtask : ack

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_state();
        chk("oe", {2'h0, pad.oe}, 8'h00);
        chk("pd_en", {2'h0, pad.pd_en}, 8'h3f);
        chk("third pd", {6'h0, upper_pd, lower_pd}, 8'h03);
        rd(sgp_pkg::OFS_PORT_PIN_DATA, rv);
        chk("pulled pins", rv, 8'h00);
    endtask : t_reset_state

    task automatic t_out_path();
        wr(sgp_pkg::OFS_PORT_PIN_DATA, 8'hea);
        wr(sgp_pkg::OFS_PORT_PIN_DIRECTION, 8'hff);
        cyc(1);
        chk("oe", {2'h0, pad.oe}, 8'h3f);
        chk("out", {2'h0, pad.out}, 8'h2a);
        chk("pd_en", {2'h0, pad.pd_en}, 8'h00);
        rd(sgp_pkg::OFS_PORT_PIN_DATA, rv);
        chk("data rd", rv, 8'h2a);
        rd(sgp_pkg::OFS_PORT_PIN_DIRECTION, rv);
        chk("dir rd", rv, 8'h3f);
    endtask : t_out_path

    // preload the latch while the pins are inputs, then turn them round
    task automatic t_in_path();
        wr(sgp_pkg::OFS_PORT_PIN_DIRECTION, 8'h00);
        ext_en <= 6'h3f;
        ext_val <= 6'h33;
        wr(sgp_pkg::OFS_PORT_PIN_DATA, 8'h15);
        cyc(4);
        rd(sgp_pkg::OFS_PORT_PIN_DATA, rv);
        chk("pin rd", rv, 8'h33);
        ext_en <= 6'h00;
        wr(sgp_pkg::OFS_PORT_PIN_DIRECTION, 8'h3f);
        cyc(1);
        chk("preload", {2'h0, pad.out}, 8'h15);
    endtask : t_in_path

    // the inhibit register is always written whole, never read back and merged
    task automatic t_pulldown();
        wr(sgp_pkg::OFS_PORT_PIN_DIRECTION, 8'h02);
        wr(sgp_pkg::OFS_PULLDOWN_INHIBIT, 8'h45);
        cyc(1);
        chk("pd_en", {2'h0, pad.pd_en}, 8'h38);
        chk("third pd", {6'h0, upper_pd, lower_pd}, 8'h02);
        wr(sgp_pkg::OFS_PULLDOWN_INHIBIT, 8'h80);
        cyc(1);
        chk("third pd", {6'h0, upper_pd, lower_pd}, 8'h01);
        rd(sgp_pkg::OFS_PULLDOWN_INHIBIT, rv);
        chk("pd rd", rv, 8'h00);
        wr(sgp_pkg::OFS_OPTION_REGISTER, 8'h01);
        cyc(1);
        chk("pd global", {2'h0, pad.pd_en}, 8'h00);
        wr(sgp_pkg::OFS_OPTION_REGISTER, 8'h00);
    endtask : t_pulldown

    task automatic t_comparator();
        wr(sgp_pkg::OFS_PORT_PIN_DATA, 8'h00);
        wr(sgp_pkg::OFS_PORT_PIN_DIRECTION, 8'h00);
        cmp_drive <= 2'h3;
        cyc(2);
        chk("cmp blocked", {2'h0, pad.out}, 8'h00);
        wr(sgp_pkg::OFS_PORT_PIN_DIRECTION, 8'h30);
        cyc(2);
        chk("cmp out", {2'h0, pad.out & pad.oe}, 8'h30);
        cmp_drive <= 2'h0;
    endtask : t_comparator

    task automatic t_irq();
        wr(sgp_pkg::OFS_PORT_PIN_DIRECTION, 8'h00);
        ext_en <= 6'h3f;
        ext_val <= 6'h00;
        cyc(4);
        ext_val <= 6'h01;
        cyc(8);
        chk("irq off", {7'h0, irq_o}, 8'h00);
        ext_val <= 6'h00;
        wr(sgp_pkg::OFS_OPTION_REGISTER, 8'h02);
        cyc(4);
        ext_val <= 6'h10;
        cyc(8);
        chk("irq pin4", {7'h0, irq_o}, 8'h00);
        ext_val <= 6'h18;
        wait_irq();
        ack();
        chk("edge only", {7'h0, irq_o}, 8'h00);
        wr(sgp_pkg::OFS_OPTION_REGISTER, 8'h06);
        cyc(4);
        chk("level", {7'h0, irq_o}, 8'h01);
        ext_val <= 6'h00;
        cyc(4);
        ack();
        chk("level low", {7'h0, irq_o}, 8'h00);
    endtask : t_irq

    task automatic t_int_pin();
        wr(sgp_pkg::OFS_OPTION_REGISTER, 8'h02);
        int_pin_i <= 1'b0;
        cyc(5);
        chk("int level", {7'h0, int_pin_level_o}, 8'h00);
        ext_val <= 6'h01;
        wait_irq();
        chk("int level", {7'h0, int_pin_level_o}, 8'h00);
        int_pin_i <= 1'b1;
        cyc(5);
        chk("int level", {7'h0, int_pin_level_o}, 8'h01);
        ack();
        ext_en <= 6'h00;
    endtask : t_int_pin

    // a reset in mid-run must keep the latch and drop the drivers
    task automatic t_reset_keep();
        wr(sgp_pkg::OFS_PORT_PIN_DATA, 8'h2d);
        wr(sgp_pkg::OFS_PORT_PIN_DIRECTION, 8'h3f);
        do_reset();
        chk("oe", {2'h0, pad.oe}, 8'h00);
        chk("kept", {2'h0, pad.out}, 8'h2d);
        wr(sgp_pkg::OFS_PORT_PIN_DIRECTION, 8'h3f);
        rd(sgp_pkg::OFS_PORT_PIN_DATA, rv);
        chk("kept rd", rv, 8'h2d);
    endtask : t_reset_keep

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_n_i, irq_ack_i, int_pin_i} = 3'h1;
        {bus, ext_en, ext_val, cmp_drive} = '0;
        {miscompares, tests_run} = '0;
        do_reset();
        t_reset_state();
        t_out_path();
        t_in_path();
        t_pulldown();
        t_comparator();
        t_irq();
        t_int_pin();
        t_reset_keep();
        tally_and_finish();
    end

    // watchdog, far beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        miscompares++;
        tally_and_finish();
    end
endmodule : tb_top
